// ### dcs_regs.svh
// register map, field codes and timing constants of the safety stop monitor
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
`define DCS_CLK_MHZ        100
`define DCS_DEB_TIME_MS    2
`define DCS_DEB_CYCLES     (`DCS_DEB_TIME_MS * 1000 * `DCS_CLK_MHZ)
`define DCS_ADDR_CTRL      8'h00
`define DCS_ADDR_FSEL0     8'h04
`define DCS_ADDR_FSEL1     8'h08
`define DCS_ADDR_FSEL2     8'h0c
`define DCS_ADDR_STATUS    8'h10
`define DCS_ADDR_FAULT     8'h14
`define DCS_FSEL_RST_RUN   8'h00
`define DCS_FSEL_RST_FREQ  8'h01
`define DCS_FSEL_RST_THIRD 8'h00
`define DCS_CODE_SAFE_POS  8'h50
`define DCS_CODE_SAFE_NEG  8'hb4
`define DCS_CODE_HLTH_POS  8'h51
`define DCS_CODE_HLTH_NEG  8'hb5
`define DCS_CODE_RUN       8'h00
`define DCS_CODE_FREQ      8'h01
`define DCS_FLT_NONE       3'h0
`define DCS_FLT_MISMATCH   3'h1
`define DCS_FLT_CODE_B     3'h2
`define DCS_FLT_CODE_C     3'h3
`define DCS_FLT_CODE_D     3'h4
`define DCS_DISP_RUN       2'h0
`define DCS_DISP_SAFE_STOP 2'h1
`define DCS_DISP_FAULT     2'h2
`define DCS_RESP_OKAY      2'h0
`define DCS_RESP_SLVERR    2'h2
`endif

// ### dcs_pkg.sv
// types of the safety stop monitor
package dcs_pkg;
    typedef enum logic [1:0] {
        DCS_DISP_IDLE,
        DCS_DISP_STOP,
        DCS_DISP_FLT
    } dcs_disp_t;
endpackage

// ### dcs_debounce.sv
// one debounced channel: level accepted after a stable hold time
`timescale 1ns/1ns
`include "dcs_regs.svh"
module dcs_debounce #(
    // hold time in clock cycles; the counter below limits it to 2**18
    parameter int unsigned HOLD_CYCLES = `DCS_DEB_CYCLES
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // raw and filtered level
    input  wire logic i_raw,
    output logic      o_level
);
    localparam int unsigned CNT_MAX = HOLD_CYCLES;
    logic [17:0] cnt_q;
    logic        level_q;
    wire         differs = (i_raw != level_q);
    wire         expired = (cnt_q == 18'(CNT_MAX - 1));

    // short glitches restart the count and are never accepted
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_q   <= 18'h0;
            level_q <= 1'b0;
        end else if (!differs) begin
            cnt_q <= 18'h0;
        end else if (expired) begin
            cnt_q   <= 18'h0;
            level_q <= i_raw;
        end else begin
            cnt_q <= cnt_q + 18'h1;
        end
    end
    assign o_level = level_q;

    AST_DEB_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
        $changed(level_q) |-> $past(cnt_q) == 18'(CNT_MAX - 1))
        else $error("level accepted before hold time");
endmodule

// ### dcs_safety_stop.sv
// dual-channel safety stop monitor with axi4-lite register slave
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dcs_regs.svh"
// Functional notes
// - two independent channels; open requests stop, short means run.
// - channel level must hold 2 ms before it is accepted.
// - drive enabled only with both shorted and no internal failure.
// - stop status on when both open and no failure.
// - stop status off when drive enabled or stopped by failure.
// - health output on exactly while powered and no failure exists.
// - mismatched channels count as failure; both outputs off, drive off.
// - health routed to run terminal turns it off on fault.
// - code 80 routes stop status positive, 180 negative, any terminal.
// - code 81 routes health positive, 181 negative, any terminal.
// - frequency terminal defaults to frequency detection; 80 selects stop status.
// - run terminal defaults to running indication; 81 selects health.
// - failure shows one of four distinct fault codes on display.
// - both open and no failure shows the safe-stop display.
// - asserted output conducts its open-collector transistor; else off.
module dcs_safety_stop #(
    // filter hold in clock cycles; only a bench shortens it, hardware keeps 2 ms
    parameter int unsigned DEB_CYCLES = `DCS_DEB_CYCLES
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // safety inputs, high = shorted to common
    input  wire logic        i_safety_channel_a,
    input  wire logic        i_safety_channel_b,
    input  wire logic        i_power_ok,
    input  wire logic [2:0]  i_int_fault_code,
    // inverter status sources
    input  wire logic        i_inverter_running,
    input  wire logic        i_freq_detect,
    // drive decision and terminals, high = transistor conducting
    output logic             o_drive_enable,
    output logic             o_run_terminal,
    output logic             o_freq_detect_terminal,
    output logic             o_third_terminal,
    output logic [1:0]       o_safe_stop_display,
    output logic [2:0]       o_fault_code,
    // axi4-lite slave
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);
    logic        ch_a;
    logic        ch_b;
    logic [7:0]  fsel_q [3];
    logic        aw_q;
    logic        w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        wlane_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        drive_q;
    logic [2:0]  fault_q;
    dcs_pkg::dcs_disp_t disp_q;
    logic [2:0]  term_q;

    // two independent filters, one per channel
    dcs_debounce #(.HOLD_CYCLES(DEB_CYCLES)) u_deb_a (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_raw   (i_safety_channel_a),
        .o_level (ch_a)
    );
    dcs_debounce #(.HOLD_CYCLES(DEB_CYCLES)) u_deb_b (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_raw   (i_safety_channel_b),
        .o_level (ch_b)
    );

    // safety decision
    wire        mismatch  = ch_a ^ ch_b;
    wire        failure   = mismatch || (i_int_fault_code != `DCS_FLT_NONE);
    wire        health    = i_power_ok && !failure;
    wire        both_open = !ch_a && !ch_b;
    wire        safe_stat = i_power_ok && both_open && !failure;
    wire        drive_d   = i_power_ok && ch_a && ch_b && !failure;
    wire [2:0]  fault_d   = !i_power_ok ? `DCS_FLT_NONE :
                            (i_int_fault_code != `DCS_FLT_NONE) ? i_int_fault_code :
                            mismatch ? `DCS_FLT_MISMATCH : `DCS_FLT_NONE;

    // terminal function decode, shared by all three terminals
    function automatic logic route(input logic [7:0] code, input logic stat,
                                   input logic hlth, input logic run, input logic frq);
        unique case (code)
            `DCS_CODE_SAFE_POS: route = stat;
            `DCS_CODE_SAFE_NEG: route = !stat;
            `DCS_CODE_HLTH_POS: route = hlth;
            `DCS_CODE_HLTH_NEG: route = !hlth;
            `DCS_CODE_RUN:      route = run;
            `DCS_CODE_FREQ:     route = frq;
            default:            route = 1'b0;
        endcase
    endfunction

    // without power every transistor stays off, negative logic included
    logic [2:0] term_d;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_term
            assign term_d[gi] = i_power_ok &&
                route(fsel_q[gi], safe_stat, health, i_inverter_running, i_freq_detect);
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            drive_q <= 1'b0;
            fault_q <= `DCS_FLT_NONE;
            term_q  <= 3'h0;
        end else begin
            drive_q <= drive_d;
            fault_q <= fault_d;
            term_q  <= term_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            disp_q <= dcs_pkg::DCS_DISP_IDLE;
        end else if (fault_d != `DCS_FLT_NONE) begin
            disp_q <= dcs_pkg::DCS_DISP_FLT;
        end else if (safe_stat) begin
            disp_q <= dcs_pkg::DCS_DISP_STOP;
        end else begin
            disp_q <= dcs_pkg::DCS_DISP_IDLE;
        end
    end

    assign o_drive_enable         = drive_q;
    assign o_run_terminal         = term_q[0];
    assign o_freq_detect_terminal = term_q[1];
    assign o_third_terminal       = term_q[2];
    assign o_fault_code           = fault_q;
    assign o_safe_stop_display    = (disp_q == dcs_pkg::DCS_DISP_FLT)  ? `DCS_DISP_FAULT :
                                    (disp_q == dcs_pkg::DCS_DISP_STOP) ? `DCS_DISP_SAFE_STOP :
                                    `DCS_DISP_RUN;

    // axi4-lite write path: address and data taken in either order
    wire aw_take = i_awvalid && o_awready;
    wire w_take  = i_wvalid && o_wready;
    assign o_awready = !aw_q && !bvalid_q;
    assign o_wready  = !w_q && !bvalid_q;
    wire wr_go   = aw_q && w_q && !bvalid_q;
    wire [1:0] wr_idx   = awaddr_q[3:2];
    wire       wr_fsel  = (awaddr_q == `DCS_ADDR_FSEL0) || (awaddr_q == `DCS_ADDR_FSEL1) ||
                          (awaddr_q == `DCS_ADDR_FSEL2);
    wire       wr_ok    = wr_fsel || (awaddr_q == `DCS_ADDR_CTRL) ||
                          (awaddr_q == `DCS_ADDR_STATUS) || (awaddr_q == `DCS_ADDR_FAULT);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0;
            wlane_q  <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= `DCS_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_q     <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (w_take) begin
                w_q     <= 1'b1;
                wdata_q <= i_wdata;
                wlane_q <= i_wstrb[0];
            end
            if (wr_go) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // function selectors; only the low byte lane carries the code
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fsel_q[0] <= `DCS_FSEL_RST_RUN;
            fsel_q[1] <= `DCS_FSEL_RST_FREQ;
            fsel_q[2] <= `DCS_FSEL_RST_THIRD;
        end else if (wr_go && wr_fsel && wlane_q) begin
            fsel_q[wr_idx - 2'h1] <= wdata_q[7:0];
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp  = bresp_q;

    // read path, one cycle latency
    assign o_arready = !rvalid_q;
    wire [31:0] rd_status = {26'h0, term_q, health, safe_stat, drive_q};
    wire        rd_ok = (i_araddr == `DCS_ADDR_CTRL)  || (i_araddr == `DCS_ADDR_FSEL0) ||
                        (i_araddr == `DCS_ADDR_FSEL1) || (i_araddr == `DCS_ADDR_FSEL2) ||
                        (i_araddr == `DCS_ADDR_STATUS) || (i_araddr == `DCS_ADDR_FAULT);
    wire [31:0] rd_mux =
        (i_araddr == `DCS_ADDR_FSEL0)  ? {24'h0, fsel_q[0]} :
        (i_araddr == `DCS_ADDR_FSEL1)  ? {24'h0, fsel_q[1]} :
        (i_araddr == `DCS_ADDR_FSEL2)  ? {24'h0, fsel_q[2]} :
        (i_araddr == `DCS_ADDR_STATUS) ? rd_status :
        (i_araddr == `DCS_ADDR_FAULT)  ? {27'h0, ch_b, ch_a, 3'h0} | {29'h0, fault_q} :
        (i_araddr == `DCS_ADDR_CTRL)   ? {31'h0, i_power_ok} : 32'h0;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `DCS_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_ok ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign o_rvalid = rvalid_q;
    assign o_rdata  = rdata_q;
    assign o_rresp  = rresp_q;

    sequence s_mismatch;
        ch_a != ch_b;
    endsequence

    // both open on a healthy circuit while the freq terminal carries stop status
    sequence s_stop_on_freq;
        fsel_q[1] == `DCS_CODE_SAFE_POS && i_power_ok && !ch_a && !ch_b
        && i_int_fault_code == `DCS_FLT_NONE;
    endsequence

    AST_DRIVE_ONLY_BOTH_SHORT: assert property (@(posedge i_clk) disable iff (i_srst)
        o_drive_enable |-> $past(ch_a && ch_b && i_power_ok))
        else $error("drive enabled without both channels shorted");
    AST_DRIVE_NO_FAULT: assert property (@(posedge i_clk) disable iff (i_srst)
        o_drive_enable |-> $past(i_int_fault_code) == `DCS_FLT_NONE)
        else $error("drive enabled during internal failure");
    AST_MISMATCH_SHUTS: assert property (@(posedge i_clk) disable iff (i_srst)
        s_mismatch |=> !o_drive_enable && (o_fault_code == `DCS_FLT_MISMATCH
                       || $past(i_int_fault_code) != `DCS_FLT_NONE || !$past(i_power_ok)))
        else $error("mismatch not treated as failure");
    AST_STOP_STATUS: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_power_ok && !ch_a && !ch_b && i_int_fault_code == `DCS_FLT_NONE)
        |=> o_safe_stop_display == `DCS_DISP_SAFE_STOP)
        else $error("safe stop display missing");
    AST_STOP_ON: assert property (@(posedge i_clk) disable iff (i_srst)
        s_stop_on_freq |=> o_freq_detect_terminal)
        else $error("stop status not shown on frequency terminal");
    AST_STOP_OFF_FAIL: assert property (@(posedge i_clk) disable iff (i_srst)
        (fsel_q[1] == `DCS_CODE_SAFE_POS
         && (ch_a != ch_b || i_int_fault_code != `DCS_FLT_NONE))
        |=> !o_freq_detect_terminal)
        else $error("stop status on during failure");
    AST_NO_STATUS_WHEN_DRIVE: assert property (@(posedge i_clk) disable iff (i_srst)
        o_drive_enable |-> !$past(safe_stat))
        else $error("stop status while drive enabled");
    AST_HEALTH_ROUTE: assert property (@(posedge i_clk) disable iff (i_srst)
        fsel_q[0] == `DCS_CODE_HLTH_POS
        |=> o_run_terminal == $past(i_power_ok && ch_a == ch_b
                                    && i_int_fault_code == `DCS_FLT_NONE))
        else $error("health output does not follow failure state");
    AST_HEALTH_ON_RUN: assert property (@(posedge i_clk) disable iff (i_srst)
        (fsel_q[0] == `DCS_CODE_HLTH_POS && failure) |=> !o_run_terminal)
        else $error("run terminal on during fault");
    AST_RUN_DEFAULT: assert property (@(posedge i_clk) disable iff (i_srst)
        fsel_q[0] == `DCS_CODE_RUN
        |=> o_run_terminal == $past(i_inverter_running && i_power_ok))
        else $error("run terminal does not show running");
    AST_FREQ_DEFAULT: assert property (@(posedge i_clk) disable iff (i_srst)
        fsel_q[1] == `DCS_CODE_FREQ
        |=> o_freq_detect_terminal == $past(i_freq_detect && i_power_ok))
        else $error("freq terminal does not show frequency detection");
    AST_POWER_OFF_SAFE: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_power_ok |=> !o_drive_enable && o_run_terminal == 1'b0
                        && o_freq_detect_terminal == 1'b0)
        else $error("outputs active without power");
    AST_FAULT_CODE: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_power_ok && i_int_fault_code != `DCS_FLT_NONE) |=> o_fault_code != `DCS_FLT_NONE
        && o_safe_stop_display == `DCS_DISP_FAULT)
        else $error("fault code not shown");
    AST_NEG_LOGIC: assert property (@(posedge i_clk) disable iff (i_srst)
        (fsel_q[2] == `DCS_CODE_SAFE_NEG && i_power_ok && $stable(fsel_q[2]))
        |=> o_third_terminal == !$past(safe_stat))
        else $error("negative logic stop status wrong");
endmodule

// ### dcs_relay_model.sv
// behavioural safety relay module: drives both channel contacts, reads feedback
`timescale 1ns/1ns
module dcs_relay_model (
    // clock and stop requests
    input  wire logic i_clk,
    input  wire logic i_open_a,
    input  wire logic i_open_b,
    // contacts and feedback
    output logic      o_safety_channel_a,
    output logic      o_safety_channel_b,
    input  wire logic i_feedback,
    output logic      o_restart_block
);
    // each contact switched on its own, open means stop request
    always_ff @(posedge i_clk) begin
        o_safety_channel_a <= ~i_open_a;
        o_safety_channel_b <= ~i_open_b;
    end
    // health feedback off keeps the drive from restarting
    assign o_restart_block = ~i_feedback;
endmodule

// ### dual_channel_safety_stop_bench.sv
// self-checking bench for the safety stop monitor
`timescale 1ns/1ns
`include "dcs_regs.svh"
module dual_channel_safety_stop_bench;
    logic        i_clk, i_srst, i_power_ok, i_inverter_running, i_freq_detect;
    logic [2:0]  i_int_fault_code, o_fault_code;
    logic [7:0]  i_awaddr, i_araddr;
    logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [31:0] i_wdata, o_rdata, d;
    logic [3:0]  i_wstrb;
    logic        open_a, open_b, ch_a, ch_b, restart_block;
    logic        o_drive_enable, o_run_terminal, o_freq_detect_terminal, o_third_terminal;
    logic [1:0]  o_safe_stop_display, o_bresp, o_rresp, r;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    int          fails, n_checks;
    // scaled filter hold keeps the run short; hardware keeps the 2 ms default
    localparam int unsigned HOLD = 2000;

    dcs_relay_model relay (.i_clk(i_clk), .i_open_a(open_a), .i_open_b(open_b),
        .o_safety_channel_a(ch_a), .o_safety_channel_b(ch_b),
        .i_feedback(o_run_terminal), .o_restart_block(restart_block));

    dcs_safety_stop #(.DEB_CYCLES(HOLD)) dut (.i_clk(i_clk), .i_srst(i_srst),
        .i_safety_channel_a(ch_a), .i_safety_channel_b(ch_b), .i_power_ok(i_power_ok),
        .i_int_fault_code(i_int_fault_code),
        .i_inverter_running(i_inverter_running), .i_freq_detect(i_freq_detect),
        .o_drive_enable(o_drive_enable), .o_run_terminal(o_run_terminal),
        .o_freq_detect_terminal(o_freq_detect_terminal), .o_third_terminal(o_third_terminal),
        .o_safe_stop_display(o_safe_stop_display), .o_fault_code(o_fault_code),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tmo(input string what);
        fails++;
        $display("BAD %s expected done seen timeout", what);
        give_verdict();
    endtask

    // bready held from the offer on, so the answer is taken at its first edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        int k;
        @(posedge i_clk);
        i_awaddr  <= a;
        i_wdata   <= v;
        i_wstrb   <= s;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge i_clk);
            if (i_awvalid && o_awready)
                i_awvalid <= 1'b0;
            if (i_wvalid && o_wready)
                i_wvalid <= 1'b0;
            if (i_bready && o_bvalid) begin
                i_bready <= 1'b0;
                r = o_bresp;
                return;
            end
        end
        tmo("write");
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge i_clk);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge i_clk);
            if (i_arvalid && o_arready)
                i_arvalid <= 1'b0;
            if (i_rready && o_rvalid) begin
                i_rready <= 1'b0;
                d = o_rdata;
                r = o_rresp;
                return;
            end
        end
        tmo("read");
    endtask

    task automatic wait_disp(input logic [1:0] e);
        int k;
        for (k = 0; k < HOLD + 50; k++) begin
            @(posedge i_clk);
            if (o_safe_stop_display === e)
                return;
        end
        tmo("display");
    endtask

    task automatic outs(input logic drv, input logic [2:0] st, input logic [1:0] dsp,
                        input logic [2:0] fc);
        chk("drive", o_drive_enable, drv);
        chk("display", o_safe_stop_display, dsp);
        chk("fault code", o_fault_code, fc);
        rd(`DCS_ADDR_STATUS);
        chk("status", d[2:0], st);
    endtask

    task automatic terms(input logic [2:0] e);
        chk("terminals", {o_third_terminal, o_freq_detect_terminal, o_run_terminal}, e);
    endtask

    task automatic t_reset;
        repeat (3) @(posedge i_clk);
        terms(3'b010);
        i_inverter_running <= 1'b1;
        i_freq_detect      <= 1'b0;
        repeat (3) @(posedge i_clk);
        terms(3'b101);
        rd(`DCS_ADDR_FSEL0);
        chk("run sel", d[7:0], `DCS_FSEL_RST_RUN);
        rd(`DCS_ADDR_FSEL1);
        chk("freq sel", d[7:0], `DCS_FSEL_RST_FREQ);
        rd(`DCS_ADDR_FSEL2);
        chk("third sel", d[7:0], `DCS_FSEL_RST_THIRD);
        rd(8'h20);
        chk("unmapped read", r, `DCS_RESP_SLVERR);
        wr(8'h20, 32'h0000_0051, 4'hf);
        chk("unmapped write", r, `DCS_RESP_SLVERR);
        // low byte not strobed: code must stay at running indication
        wr(`DCS_ADDR_FSEL0, 32'h0000_0051, 4'he);
        rd(`DCS_ADDR_FSEL0);
        chk("unstrobed sel", d[7:0], `DCS_FSEL_RST_RUN);
        i_inverter_running <= 1'b0;
        $display("test reset done");
    endtask

    task automatic t_arm;
        int k;
        // a short that ends just inside the hold time must leave no trace
        open_a <= 1'b0;
        open_b <= 1'b0;
        repeat (HOLD - 10) @(posedge i_clk);
        open_a <= 1'b1;
        open_b <= 1'b1;
        repeat (20) @(posedge i_clk);
        chk("short pulse drive", o_drive_enable, 1'b0);
        open_a <= 1'b0;
        open_b <= 1'b0;
        // stable shorted inputs must wait out the whole hold time
        repeat (HOLD) @(posedge i_clk);
        chk("early drive", o_drive_enable, 1'b0);
        for (k = 0; k < 20 && o_drive_enable !== 1'b1; k++)
            @(posedge i_clk);
        if (k == 20)
            tmo("drive enable");
        repeat (2) @(posedge i_clk);
        outs(1'b1, 3'b101, `DCS_DISP_RUN, `DCS_FLT_NONE);
        $display("test arm done");
    endtask

    task automatic t_route;
        // an unassigned code must turn the transistor off
        logic [7:0] adr [5] = '{`DCS_ADDR_FSEL0, `DCS_ADDR_FSEL1, `DCS_ADDR_FSEL2,
                                `DCS_ADDR_FSEL2, `DCS_ADDR_FSEL2};
        logic [7:0] cod [5] = '{`DCS_CODE_HLTH_POS, `DCS_CODE_SAFE_POS, `DCS_CODE_SAFE_NEG,
                                8'h02, `DCS_CODE_HLTH_NEG};
        logic [2:0] exp [5] = '{3'b001, 3'b001, 3'b101, 3'b001, 3'b001};
        int         k;
        for (k = 0; k < 5; k++) begin
            wr(adr[k], {24'h0, cod[k]}, 4'hf);
            repeat (3) @(posedge i_clk);
            terms(exp[k]);
        end
        $display("test route done");
    endtask

    task automatic t_fault;
        int c;
        for (c = 2; c <= 4; c++) begin
            i_int_fault_code <= 3'(c);
            repeat (3) @(posedge i_clk);
            outs(1'b0, 3'b000, `DCS_DISP_FAULT, 3'(c));
            terms(3'b100);
            chk("restart block", restart_block, 1'b1);
        end
        i_int_fault_code <= 3'h0;
        repeat (3) @(posedge i_clk);
        chk("drive back", o_drive_enable, 1'b1);
        $display("test fault done");
    endtask

    task automatic t_mismatch;
        open_b <= 1'b1;
        wait_disp(`DCS_DISP_FAULT);
        repeat (2) @(posedge i_clk);
        outs(1'b0, 3'b000, `DCS_DISP_FAULT, `DCS_FLT_MISMATCH);
        terms(3'b100);
        rd(`DCS_ADDR_FAULT);
        chk("fault reg", d[4:0], {2'b01, `DCS_FLT_MISMATCH});
        $display("test mismatch done");
    endtask

    task automatic t_stop;
        open_a <= 1'b1;
        wait_disp(`DCS_DISP_SAFE_STOP);
        repeat (2) @(posedge i_clk);
        outs(1'b0, 3'b110, `DCS_DISP_SAFE_STOP, `DCS_FLT_NONE);
        terms(3'b011);
        chk("restart block", restart_block, 1'b0);
        $display("test stop done");
    endtask

    task automatic t_power;
        i_power_ok <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("drive", o_drive_enable, 1'b0);
        terms(3'b000);
        rd(`DCS_ADDR_STATUS);
        chk("status off", d[5:0], 6'h00);
        rd(`DCS_ADDR_CTRL);
        chk("power bit", d[0], 1'b0);
        $display("test power done");
    endtask

    initial begin
        fails = 0;
        n_checks = 0;
        {i_srst, i_power_ok, open_a, open_b, i_freq_detect} = 5'h1f;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_inverter_running} = 6'h0;
        {i_awaddr, i_araddr, i_wdata, i_wstrb, i_int_fault_code} = '0;
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        t_reset();
        t_arm();
        t_route();
        t_fault();
        t_mismatch();
        t_stop();
        t_power();
        give_verdict();
    end
endmodule
